/* src/node_cfg.svh */
// Purpose: Offsets, object indices, timing figures and codes for the slave node block
// Assumes: Included by its bare name
// Notes:   Byte addresses on an AXI4-Lite register window
`ifndef NODE_CFG_SVH
`define NODE_CFG_SVH
`define OFS_STATE_REQ     12'h000
`define OFS_STATE_STAT    12'h004
`define OFS_OBJ_ADDR      12'h008
`define OFS_OBJ_WDATA     12'h00C
`define OFS_OBJ_CMD       12'h010
`define OFS_OBJ_RDATA     12'h014
`define OFS_OBJ_STAT      12'h018
`define OFS_CHAN_CFG      12'h01C
`define OFS_CHECK_OK      12'h020
`define OFS_INPUT_DATA    12'h024
`define OFS_OUTPUT_DATA   12'h028
`define OFS_SAFE_VALUE    12'h02C
`define OFS_WDOG_CTRL     12'h030
`define OFS_NVM_STAT      12'h034
`define IDX_IDENTITY      16'h1000
`define IDX_CHAN_LEGACY   16'h4000
`define IDX_INPUT_PDO     16'h6000
`define IDX_OUTPUT_PDO    16'h7000
`define IDX_CHAN_PARAM    16'h8000
`define IDX_WRITE_SUPP    16'hF008
`define CHAN_STRIDE       16'h0010
`define SUPPRESS_CODE     32'h12345678
`define NVM_WRITE_NS      1000
`define CLK_PERIOD_NS     25
`define NVM_WRITE_CYC     ((`NVM_WRITE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10
`endif

/* src/node_pkg.sv */
// Purpose: Types for the slave node block
// Assumes: Nothing
// Notes:   One-hot state codes
package node_pkg;
    typedef enum logic [4:0] {
        ST_INIT   = 5'b00001,
        ST_MBOX   = 5'b00010,
        ST_HELD   = 5'b00100,
        ST_RUN    = 5'b01000,
        ST_BOOT   = 5'b10000
    } node_state_t;
    typedef enum logic [1:0] {
        REGION_OTHER = 2'b00,
        REGION_RO    = 2'b01,
        REGION_CHAN  = 2'b10,
        REGION_SUPP  = 2'b11
    } region_t;
endpackage

/* src/slave_state_machine.sv */
// Purpose: Slave state machine and parameter object dictionary behind AXI4-Lite
// Assumes: clock_in 40 MHz, srst_in synchronous active high, one bus master
// Notes:   Non-volatile storage is modelled by a write-busy timer and a commit count
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "node_cfg.svh"

// Operation
// - After reset the node sits in Init with mailbox and process data refused.
// - Init to mailbox config only when the mailbox channel check passes.
// - Mailbox config state allows mailbox, blocks process data.
// - Entering outputs-held checks process data channels and clock settings; the code checks them only on entry from mailbox config, not from full run.
// - Inputs are copied into dual-port area before outputs-held is acknowledged.
// - Outputs-held allows both traffics, inputs update, outputs stay safe.
// - Full run drives outputs from master data; both traffics allowed.
// - Boot is reachable only from Init.
// - Boot allows only file-transfer mailbox, rejects everything else.
// - Watchdog off lets outputs be driven in outputs-held as well.
// - Objects are addressed by 16-bit index and 8-bit subindex.
// - Identity objects live from 0x1000 and are read only.
// - Channel parameters at 0x8000, legacy 0x4000 mirrors the same storage.
// - Input objects from 0x6000, output objects from 0x7000.
// - Access follows object attributes; writes to read-only objects are refused.
// - Changed parameters are committed to non-volatile memory.
// - Code 0x12345678 at 0xF008 suppresses saving; off after reset.
// - Each channel owns sixteen indices starting at base plus n times 0x10.
module slave_state_machine
    import node_pkg::*;
#(
    parameter int CHANNELS = 4,
    parameter int DATA_W   = 32
) (
    // Clock and reset
    input  wire logic              clock_in,
    input  wire logic              srst_in,
    // AXI4-Lite write
    input  wire logic [11:0]       s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read
    input  wire logic [11:0]       s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Process side
    input  wire logic [DATA_W-1:0] phys_inputs_in,
    output logic [DATA_W-1:0]      phys_outputs_out,
    // Traffic gating and status
    output logic                   mailbox_enable_out,
    output logic                   file_transfer_only_out,
    output logic                   process_data_enable_out,
    output logic [4:0]             state_out,
    output logic                   state_error_out,
    output logic                   nvm_write_out
);

    localparam int CH_W = $clog2(CHANNELS);

    node_state_t         state_r;
    logic                err_r;
    logic [3:0]          chk_r;        // dc, dc_used, pd, mbox
    logic [DATA_W-1:0]   in_dpram_r;
    logic [DATA_W-1:0]   out_data_r;
    logic [DATA_W-1:0]   safe_r;
    logic [DATA_W-1:0]   out_r;
    logic                wdog_on_r;
    logic [15:0]         obj_index_r;
    logic [7:0]          obj_sub_r;
    logic [31:0]         obj_wdata_r;
    logic [31:0]         obj_rdata_r;
    logic [1:0]          obj_stat_r;   // refused, done
    logic [31:0]         supp_r;
    logic [15:0]         nvm_cnt_r;
    logic [15:0]         nvm_commits_r;
    logic [31:0]         chan_mem [CHANNELS*16];
    logic [31:0]         chan_cfg_r;

    // AXI write capture
    logic                aw_have_r;
    logic                w_have_r;
    logic [11:0]         aw_addr_r;
    logic [31:0]         w_data_r;
    logic [3:0]          w_strb_r;
    logic                wr_go;
    logic                wr_ok;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Channel blocks of sixteen indices in either parameter window
    function automatic region_t classify(input logic [15:0] idx);
        if (idx == `IDX_WRITE_SUPP) begin
            return REGION_SUPP;
        end else if (idx[15:12] == `IDX_IDENTITY >> 12 || idx[15:12] == `IDX_INPUT_PDO >> 12) begin
            return REGION_RO;
        end else if (idx[15:12] == `IDX_CHAN_PARAM >> 12 || idx[15:12] == `IDX_CHAN_LEGACY >> 12)
        begin
            return REGION_CHAN;
        end else begin
            return REGION_OTHER;
        end
    endfunction

    function automatic logic chan_hit(input logic [15:0] idx);
        return (classify(idx) == REGION_CHAN) && (32'(idx[11:4]) < CHANNELS);
    endfunction

    assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_r && !s_axi_bvalid;
    assign wr_go         = aw_have_r && w_have_r && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        wr_ok = 1'b1;
        if (aw_addr_r > `OFS_NVM_STAT || aw_addr_r[1:0] != 2'b00) begin
            wr_ok = 1'b0;
        end else if (aw_addr_r == `OFS_STATE_STAT || aw_addr_r == `OFS_OBJ_RDATA ||
                     aw_addr_r == `OFS_OBJ_STAT || aw_addr_r == `OFS_NVM_STAT) begin
            wr_ok = 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            aw_have_r    <= 1'b0;
            w_have_r     <= 1'b0;
            aw_addr_r    <= 12'h000;
            w_data_r     <= 32'h00000000;
            w_strb_r     <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_r    <= 1'b0;
                w_have_r     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic wr_req;
    logic wr_obj;
    assign wr_req = wr_go && wr_ok && aw_addr_r == `OFS_STATE_REQ;
    assign wr_obj = wr_go && wr_ok && aw_addr_r == `OFS_OBJ_CMD;

    // Plain control registers
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            obj_index_r <= 16'h0000;
            obj_sub_r   <= 8'h00;
            obj_wdata_r <= 32'h00000000;
            chan_cfg_r  <= 32'h00000000;
            chk_r       <= 4'h0;
            out_data_r  <= '0;
            safe_r      <= '0;
            wdog_on_r   <= 1'b1;
        end else if (wr_go && wr_ok) begin
            if (aw_addr_r == `OFS_OBJ_ADDR) begin
                {obj_index_r, obj_sub_r} <= 24'(merge({8'h00, obj_index_r, obj_sub_r},
                                                      w_data_r, w_strb_r));
            end else if (aw_addr_r == `OFS_OBJ_WDATA) begin
                obj_wdata_r <= merge(obj_wdata_r, w_data_r, w_strb_r);
            end else if (aw_addr_r == `OFS_CHAN_CFG) begin
                chan_cfg_r <= merge(chan_cfg_r, w_data_r, w_strb_r);
            end else if (aw_addr_r == `OFS_CHECK_OK) begin
                chk_r <= w_data_r[3:0];
            end else if (aw_addr_r == `OFS_OUTPUT_DATA) begin
                out_data_r <= DATA_W'(w_data_r);
            end else if (aw_addr_r == `OFS_SAFE_VALUE) begin
                safe_r <= DATA_W'(w_data_r);
            end else if (aw_addr_r == `OFS_WDOG_CTRL) begin
                wdog_on_r <= w_data_r[0];
            end
        end
    end

    // State machine
    logic [4:0] req;
    assign req = w_data_r[4:0];

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            state_r <= ST_INIT;
            err_r   <= 1'b0;
        end else if (wr_req) begin
            err_r <= 1'b1;
            case (state_r)
                ST_INIT: begin
                    if (req == ST_MBOX && chk_r[0]) begin
                        state_r <= ST_MBOX;
                        err_r   <= 1'b0;
                    end else if (req == ST_BOOT) begin
                        state_r <= ST_BOOT;
                        err_r   <= 1'b0;
                    end else if (req == ST_INIT) begin
                        err_r   <= 1'b0;
                    end
                end
                ST_MBOX: begin
                    if (req == ST_HELD && chk_r[1] && (!chk_r[2] || chk_r[3])) begin
                        state_r <= ST_HELD;
                        err_r   <= 1'b0;
                    end else if (req == ST_INIT || req == ST_MBOX) begin
                        state_r <= node_state_t'(req);
                        err_r   <= 1'b0;
                    end
                end
                ST_HELD, ST_RUN: begin
                    if (req == ST_INIT || req == ST_MBOX || req == ST_HELD || req == ST_RUN) begin
                        state_r <= node_state_t'(req);
                        err_r   <= 1'b0;
                    end
                end
                ST_BOOT: begin
                    if (req == ST_INIT || req == ST_BOOT) begin
                        state_r <= node_state_t'(req);
                        err_r   <= 1'b0;
                    end
                end
                default: begin
                    state_r <= ST_INIT;
                end
            endcase
        end
    end

    // Input image: snapshot on entry to outputs-held, then cyclic
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            in_dpram_r <= '0;
        end else if (state_r == ST_HELD || state_r == ST_RUN ||
                     (wr_req && state_r == ST_MBOX && req == ST_HELD)) begin
            in_dpram_r <= phys_inputs_in;
        end
    end

    // Physical outputs
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            out_r <= '0;
        end else if (state_r == ST_RUN || (state_r == ST_HELD && !wdog_on_r)) begin
            out_r <= out_data_r;
        end else begin
            out_r <= safe_r;
        end
    end

    assign phys_outputs_out        = out_r;
    assign state_out               = state_r;
    assign state_error_out         = err_r;
    assign mailbox_enable_out      = state_r != ST_INIT;
    assign file_transfer_only_out  = state_r == ST_BOOT;
    assign process_data_enable_out = state_r == ST_HELD || state_r == ST_RUN;

    // Object dictionary access
    logic        wr_dir;
    logic [15:0] cidx;
    logic [CH_W+3:0] cslot;
    region_t     reg_kind;
    assign wr_dir   = w_data_r[0];
    assign reg_kind = classify(obj_index_r);
    assign cidx     = obj_index_r - (obj_index_r & 16'hF000);
    assign cslot    = (CH_W+4)'(cidx);

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            obj_rdata_r <= 32'h00000000;
            obj_stat_r  <= 2'b00;
            supp_r      <= 32'h00000000;
        end else if (wr_obj) begin
            obj_stat_r <= 2'b01;
            if (state_r == ST_INIT || state_r == ST_BOOT) begin
                obj_stat_r <= 2'b11;
            end else if (reg_kind == REGION_SUPP) begin
                if (wr_dir) supp_r <= obj_wdata_r;
                obj_rdata_r <= supp_r;
            end else if (reg_kind == REGION_RO) begin
                if (wr_dir) begin
                    obj_stat_r <= 2'b11;
                end else if (obj_index_r[15:12] == 4'h6) begin
                    obj_rdata_r <= 32'(in_dpram_r);
                end else begin
                    obj_rdata_r <= {obj_index_r, 8'h00, obj_sub_r};
                end
            end else if (obj_index_r[15:12] == 4'h7) begin
                obj_rdata_r <= 32'(out_data_r);
                if (wr_dir) obj_stat_r <= 2'b11;
            end else if (chan_hit(obj_index_r)) begin
                if (!wr_dir) obj_rdata_r <= chan_mem[cslot];
            end else begin
                obj_stat_r <= 2'b11;
            end
        end
    end

    // Legacy and current windows share one store
    always_ff @(posedge clock_in) begin
        if (wr_obj && wr_dir && state_r != ST_INIT && state_r != ST_BOOT &&
            chan_hit(obj_index_r)) begin
            chan_mem[cslot] <= obj_wdata_r;
        end
    end

    // Non-volatile commit timer
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            nvm_cnt_r     <= 16'h0000;
            nvm_commits_r <= 16'h0000;
        end else if (wr_obj && wr_dir && state_r != ST_INIT && state_r != ST_BOOT &&
                     chan_hit(obj_index_r) && supp_r != `SUPPRESS_CODE) begin
            nvm_cnt_r     <= 16'(`NVM_WRITE_CYC);
            nvm_commits_r <= nvm_commits_r + 16'h0001;
        end else if (nvm_cnt_r != 16'h0000) begin
            nvm_cnt_r <= nvm_cnt_r - 16'h0001;
        end
    end
    assign nvm_write_out = nvm_cnt_r != 16'h0000;

    // Read channel
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RESP_OKAY;
            if (s_axi_araddr == `OFS_STATE_REQ || s_axi_araddr == `OFS_STATE_STAT) begin
                s_axi_rdata <= {26'h0, err_r, state_r};
            end else if (s_axi_araddr == `OFS_OBJ_ADDR) begin
                s_axi_rdata <= {8'h00, obj_index_r, obj_sub_r};
            end else if (s_axi_araddr == `OFS_OBJ_WDATA) begin
                s_axi_rdata <= obj_wdata_r;
            end else if (s_axi_araddr == `OFS_OBJ_RDATA) begin
                s_axi_rdata <= obj_rdata_r;
            end else if (s_axi_araddr == `OFS_OBJ_STAT) begin
                s_axi_rdata <= {30'h0, obj_stat_r};
            end else if (s_axi_araddr == `OFS_CHAN_CFG) begin
                s_axi_rdata <= chan_cfg_r;
            end else if (s_axi_araddr == `OFS_CHECK_OK) begin
                s_axi_rdata <= {28'h0, chk_r};
            end else if (s_axi_araddr == `OFS_INPUT_DATA) begin
                s_axi_rdata <= 32'(in_dpram_r);
            end else if (s_axi_araddr == `OFS_OUTPUT_DATA) begin
                s_axi_rdata <= 32'(out_data_r);
            end else if (s_axi_araddr == `OFS_SAFE_VALUE) begin
                s_axi_rdata <= 32'(safe_r);
            end else if (s_axi_araddr == `OFS_WDOG_CTRL) begin
                s_axi_rdata <= {31'h0, wdog_on_r};
            end else if (s_axi_araddr == `OFS_NVM_STAT) begin
                s_axi_rdata <= {nvm_commits_r, 15'h0, nvm_write_out};
            end else begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Checks
    a_reset_init: assert property (@(posedge clock_in) srst_in |=> state_r == ST_INIT)
        else $error("not in init after reset");
    a_init_no_traffic: assert property (@(posedge clock_in) disable iff (srst_in)
        state_r == ST_INIT |-> !mailbox_enable_out && !process_data_enable_out)
        else $error("traffic open in init");
    a_mbox_check: assert property (@(posedge clock_in) disable iff (srst_in)
        $rose(state_r == ST_MBOX) && $past(state_r) == ST_INIT |-> $past(chk_r[0]))
        else $error("mailbox state without check");
    a_mbox_no_pd: assert property (@(posedge clock_in) disable iff (srst_in)
        state_r == ST_MBOX |-> mailbox_enable_out && !process_data_enable_out)
        else $error("process data in mailbox state");
    a_held_snapshot: assert property (@(posedge clock_in) disable iff (srst_in)
        $rose(state_r == ST_HELD) && $past(state_r) == ST_MBOX |->
        in_dpram_r == $past(phys_inputs_in))
        else $error("inputs not copied on entry");
    a_held_safe: assert property (@(posedge clock_in) disable iff (srst_in)
        state_r == ST_HELD && wdog_on_r ##1 state_r == ST_HELD |->
        phys_outputs_out == $past(safe_r))
        else $error("outputs not safe");
    a_run_outputs: assert property (@(posedge clock_in) disable iff (srst_in)
        state_r == ST_RUN ##1 state_r == ST_RUN |-> phys_outputs_out == $past(out_data_r))
        else $error("outputs not following master");
    a_boot_entry: assert property (@(posedge clock_in) disable iff (srst_in)
        $rose(state_r == ST_BOOT) |-> $past(state_r) == ST_INIT)
        else $error("boot entered not from init");
    a_boot_gate: assert property (@(posedge clock_in) disable iff (srst_in)
        state_r == ST_BOOT |-> file_transfer_only_out && !process_data_enable_out)
        else $error("boot traffic open");
    a_supp_nvm: assert property (@(posedge clock_in) disable iff (srst_in)
        supp_r == `SUPPRESS_CODE && nvm_cnt_r == 16'h0000 |=> nvm_cnt_r == 16'h0000)
        else $error("save while suppressed");
    a_bad_req: assert property (@(posedge clock_in) disable iff (srst_in)
        wr_req && state_r == ST_MBOX && req == ST_RUN |=> state_r == ST_MBOX && err_r)
        else $error("illegal request accepted");

endmodule

/* verif/net_master_model.sv */
// Purpose: Network master model driving the node register window
// Assumes: Ready and answers sampled at the rising edge, every change made just after it
// Notes:   Released address and data lines show inverted values, never the last ones
`timescale 1ns/1ps
module net_master_model (
    // Clock
    input  wire logic        clock_in,
    // AXI4-Lite master
    output logic [11:0]      s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [11:0]      s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready,
    // Hang flag
    output logic             hung
);
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, hung} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
    end
    // Each task ends one edge after release so the next call never reassigns in one step
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        int   n;
        logic tb;
        n = 0;
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge clock_in);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            {tb, r} = {s_axi_bvalid, s_axi_bresp};
            n++;
        end while (!tb && n < 99);
        {s_axi_bready, s_axi_awaddr, s_axi_wdata} <= {1'b0, ~a, ~d};
        if (!tb) hung = 1'b1;
        @(posedge clock_in);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int   n;
        logic tr;
        n = 0;
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge clock_in);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            {tr, d, r} = {s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            n++;
        end while (!tr && n < 99);
        {s_axi_rready, s_axi_araddr} <= {1'b0, ~a};
        if (!tr) hung = 1'b1;
        @(posedge clock_in);
    endtask
endmodule

/* verif/slave_state_machine_test.sv */
// Purpose: Self-checking bench for the slave state machine and object dictionary
// Assumes: Default CHANNELS and DATA_W, checks read back over the register window
// Notes:   Random data from a fixed seed, corner requests written by hand
`timescale 1ns/1ps
`include "node_cfg.svh"
module slave_state_machine_test;
    import node_pkg::*;
    logic        clock_in = 1'b0;
    logic        srst_in = 1'b1;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, phys_inputs_in, phys_outputs_out;
    logic [3:0]  s_axi_wstrb, ch;
    logic [4:0]  state_out;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        mailbox_enable_out, file_transfer_only_out, process_data_enable_out;
    logic        state_error_out, nvm_write_out, hung;
    logic [31:0] v, dout, dsafe, dch;
    int          errors = 0;
    int          checks = 0;
    always #12.5 clock_in = ~clock_in;
    slave_state_machine u_slave_state_machine (.*);
    net_master_model    u_net_master_model (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        u_net_master_model.wr(a, d, r);
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic rreg(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
        u_net_master_model.rd(a, v, r);
        chk(v, e);
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic req(input logic [4:0] t, input logic [4:0] s, input logic e);
        wreg(`OFS_STATE_REQ, {27'h0, t}, `RESP_OKAY);
        rreg(`OFS_STATE_REQ, {26'h0, e, s}, `RESP_OKAY);
        chk({26'h0, state_error_out, state_out}, {26'h0, e, s});
        chk({29'h0, mailbox_enable_out, process_data_enable_out, file_transfer_only_out},
            {29'h0, s != ST_INIT, s == ST_HELD || s == ST_RUN, s == ST_BOOT});
    endtask
    task automatic obj(input logic [15:0] i, input logic w, input logic [31:0] d, input logic rf);
        wreg(`OFS_OBJ_ADDR, {8'h0, i, 8'h07}, `RESP_OKAY);
        wreg(`OFS_OBJ_WDATA, d, `RESP_OKAY);
        wreg(`OFS_OBJ_CMD, {31'h0, w}, `RESP_OKAY);
        u_net_master_model.rd(`OFS_OBJ_STAT, v, r);
        chk({31'h0, v[1]}, {31'h0, rf});
    endtask
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge hung) begin
        errors++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'hC88B));
        phys_inputs_in <= $urandom();
        {dout, dsafe, dch} = {$urandom(), $urandom(), $urandom()};
        ch = 4'($urandom_range(3, 0));
        repeat (16) @(posedge clock_in);
        srst_in <= 1'b0;
        req(ST_MBOX, ST_INIT, 1'b1);
        obj(16'h8000, 1'b1, dch, 1'b1);
        wreg(`OFS_CHECK_OK, 32'h1, `RESP_OKAY);
        req(ST_MBOX, ST_MBOX, 1'b0);
        req(ST_RUN, ST_MBOX, 1'b1);
        req(ST_BOOT, ST_MBOX, 1'b1);
        wreg(`OFS_CHECK_OK, 32'h7, `RESP_OKAY);
        req(ST_HELD, ST_MBOX, 1'b1);
        obj(`IDX_CHAN_PARAM | {8'h0, ch, 4'h5}, 1'b1, dch, 1'b0);
        rreg(`OFS_NVM_STAT, 32'h0001_0001, `RESP_OKAY);
        obj(`IDX_CHAN_LEGACY | {8'h0, ch, 4'h5}, 1'b0, 32'h0, 1'b0);
        rreg(`OFS_OBJ_RDATA, dch, `RESP_OKAY);
        obj(`IDX_IDENTITY, 1'b1, dch, 1'b1);
        obj(`IDX_OUTPUT_PDO, 1'b1, dch, 1'b1);
        obj(`IDX_WRITE_SUPP, 1'b1, `SUPPRESS_CODE, 1'b0);
        for (int n = 0; n < 99 && nvm_write_out !== 1'b0; n++) @(posedge clock_in);
        chk({31'h0, nvm_write_out}, 32'h0);
        obj(`IDX_CHAN_PARAM | {8'h0, ch, 4'h0}, 1'b1, ~dch, 1'b0);
        rreg(`OFS_NVM_STAT, 32'h0001_0000, `RESP_OKAY);
        wreg(`OFS_CHECK_OK, 32'hB, `RESP_OKAY);
        wreg(`OFS_SAFE_VALUE, dsafe, `RESP_OKAY);
        wreg(`OFS_OUTPUT_DATA, dout, `RESP_OKAY);
        req(ST_HELD, ST_HELD, 1'b0);
        rreg(`OFS_INPUT_DATA, phys_inputs_in, `RESP_OKAY);
        obj(`IDX_INPUT_PDO, 1'b0, 32'h0, 1'b0);
        rreg(`OFS_OBJ_RDATA, phys_inputs_in, `RESP_OKAY);
        // Fresh inputs must reach the image while outputs are held
        phys_inputs_in <= $urandom();
        @(posedge clock_in);
        rreg(`OFS_INPUT_DATA, phys_inputs_in, `RESP_OKAY);
        chk(phys_outputs_out, dsafe);
        wreg(`OFS_WDOG_CTRL, 32'h0, `RESP_OKAY);
        rreg(`OFS_WDOG_CTRL, 32'h0, `RESP_OKAY);
        chk(phys_outputs_out, dout);
        wreg(`OFS_WDOG_CTRL, 32'h1, `RESP_OKAY);
        req(ST_RUN, ST_RUN, 1'b0);
        chk(phys_outputs_out, dout);
        req(ST_BOOT, ST_RUN, 1'b1);
        req(ST_INIT, ST_INIT, 1'b0);
        req(ST_BOOT, ST_BOOT, 1'b0);
        obj(`IDX_CHAN_PARAM, 1'b0, 32'h0, 1'b1);
        rreg(12'hFFC, 32'h0, `RESP_SLVERR);
        wreg(`OFS_NVM_STAT, dch, `RESP_SLVERR);
        // Reset in mid-run from Boot must land back in Init with no error
        srst_in <= 1'b1;
        repeat (2) @(posedge clock_in);
        srst_in <= 1'b0;
        rreg(`OFS_STATE_STAT, {27'h0, ST_INIT}, `RESP_OKAY);
        give_verdict();
    end
endmodule
